// File: hw/pin_sync.sv
// Two-stage synchroniser with edge detection for one pin
`timescale 1ns/100ps
module pin_sync (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_q; // First stage, read only by the second
  logic sync_q; // Second stage
  logic prev_q; // Delayed copy for edges
  // Sample chain, idle lines rest high
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      prev_q <= 1'b1;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end
  assign level = sync_q;
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;
endmodule // pin_sync

// File: hw/sensor_spd_pkg.sv
// Shared constants and types for the two-wire sensor and memory target
package sensor_spd_pkg;
  // Target type codes in the upper address nibble
  localparam logic [3:0] TYPE_SENSOR = 4'h3;
  localparam logic [3:0] TYPE_MEM = 4'hA;
  localparam logic [3:0] TYPE_PROT = 4'h6;
  // Sensor register pointer values
  localparam logic [2:0] PTR_CAPS = 3'h0;
  localparam logic [2:0] PTR_CFG = 3'h1;
  localparam logic [2:0] PTR_UPPER = 3'h2;
  localparam logic [2:0] PTR_LOWER = 3'h3;
  localparam logic [2:0] PTR_CRIT = 3'h4;
  localparam logic [2:0] PTR_TEMP = 3'h5;
  localparam logic [2:0] PTR_MAKER = 3'h6;
  localparam logic [2:0] PTR_DEVID = 3'h7;
  // Power-on and fixed read values
  localparam logic [2:0] PTR_RST = 3'h0;
  localparam logic [15:0] CAPS_VAL = 16'h002F;
  localparam logic [15:0] CFG_RST = 16'h0000;
  localparam logic [15:0] TRIP_RST = 16'h0000;
  localparam logic [9:0] TEMP_RST = 10'h000;
  localparam logic [7:0] MEM_RST = 8'hFF;
  localparam logic [7:0] PROT_READ_VAL = 8'hFF;
  // Configuration bit positions
  localparam int CFG_MODE_BIT = 0;
  localparam int CFG_CRIT_ONLY_BIT = 2;
  localparam int CFG_EN_BIT = 3;
  localparam int CFG_CLR_BIT = 5;
  // Timing figures
  localparam int CLK_HZ = 40_000_000;
  localparam int CONV_PERIOD_MS = 125;
  localparam int CONV_CYCLES = CONV_PERIOD_MS * (CLK_HZ / 1000);
  localparam int SCL_HZ = 400_000;
  localparam int SCL_QUARTER_CYCLES = CLK_HZ / (4 * SCL_HZ);
  // Which function an address selected
  typedef enum logic [1:0] {SEL_SENSOR, SEL_MEM, SEL_PROT} sel_t;
  // Target end states
  typedef enum logic [2:0] {D_IDLE, D_ADDR, D_ACK, D_RX, D_TX, D_TXACK} dev_state_t;
  // Master end states
  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} host_state_t;
endpackage

// File: hw/sensor_spd_target.sv
// Target end: temperature sensor and serial memory on one two-wire link
//
// Notes on behaviour
// - Sensor and memory answer separate addresses
// - Sensor answers type code 0011 only
// - Memory array answers type code 1010
// - Protection settings answer type code 0110 until protection is set
// - Straps give low three address bits
// - Straps double as memory chip selects
// - Alert is open-drain, active low
// - Alert on over-limit or outside window
// - Alert may signal critical only
// - Comparator or interrupt alert mode
// - Conversion started at least eight per second
// - Latched temperature readable at any time
// - Ten-bit result, quarter degree steps
// - Memory holds 256 bytes
// - Command protects bytes 00h to 7Fh
// - Hardware write lock held low always
// - Registers take defaults at power-on
// - Pointer keeps last written location
// - Address is type, straps, read flag
// - Master writes pointer then two bytes
`timescale 1ns/100ps
module sensor_spd_target
  import sensor_spd_pkg::*;
#(
  parameter int CONV_PERIOD = CONV_CYCLES, // Cycles between conversions
  parameter logic [15:0] MAKER_ID = 16'h1234, // Arbitrary value
  parameter logic [15:0] DEVICE_ID = 16'h0100 // Arbitrary value
) (
  input wire logic clk,
  input wire logic reset_n,
  two_wire_if.target bus,
  input wire logic addr_strap_bit0,
  input wire logic addr_strap_bit1,
  input wire logic addr_strap_bit2,
  output logic conv_start,
  input wire logic conv_done,
  input wire logic [9:0] conv_code,
  output logic protect_active
);
  logic scl_s, scl_rise, scl_fall; // Synchronised clock line
  logic sda_s, sda_rise, sda_fall; // Synchronised data line
  logic [2:0] strap_meta_q, strap_q; // Strap synchroniser
  dev_state_t state_q; // Link state
  sel_t sel_q; // Selected function
  logic read_q; // Current transfer reads
  logic [3:0] bit_q; // Bit counter
  logic [7:0] shift_q; // Receive shifter
  logic [7:0] tx_q; // Transmit shifter
  logic [7:0] idx_q; // Data byte index in transfer
  logic sda_oe_q; // Data pull-down
  logic [7:0] maddr_q; // Memory address counter
  logic [7:0] mem_q [0:255]; // Memory array
  logic wp_q; // Lower half protected
  logic [2:0] ptr_q; // Sensor register pointer
  logic [7:0] msb_q; // First byte of a register word
  logic [15:0] cfg_q, upper_q, lower_q, crit_q; // Writable sensor registers
  logic [9:0] temp_q; // Latched conversion
  logic [31:0] conv_cnt_q; // Conversion pacing
  logic cond_q, int_q, alert_q; // Alert state

  // Both line samplers
  pin_sync u_scl (.clk(clk), .reset_n(reset_n), .pin(bus.scl), .level(scl_s),
                  .rise(scl_rise), .fall(scl_fall));
  pin_sync u_sda (.clk(clk), .reset_n(reset_n), .pin(bus.sda), .level(sda_s),
                  .rise(sda_rise), .fall(sda_fall));

  // Straps are pins, so synchronise them
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_meta_q <= 3'h0;
      strap_q <= 3'h0;
    end else begin
      strap_meta_q <= {addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};
      strap_q <= strap_meta_q;
    end
  end

  // Bus conditions and address decode
  wire start_det = sda_fall & scl_s;
  wire stop_det = sda_rise & scl_s;
  wire [2:0] mem_select = strap_q; // Same bits select the memory
  wire strap_hit = shift_q[3:1] == strap_q;
  wire hit_sensor = strap_hit && shift_q[7:4] == TYPE_SENSOR;
  wire hit_mem = shift_q[3:1] == mem_select && shift_q[7:4] == TYPE_MEM;
  wire hit_prot = shift_q[3:1] == mem_select && shift_q[7:4] == TYPE_PROT && !wp_q;
  wire addr_hit = hit_sensor | hit_mem | hit_prot;
  wire byte_end = scl_fall && bit_q == 4'd8;
  wire rx_done = byte_end && state_q == D_RX;
  // Write lock pin is held low, so only the software flag blocks writes
  wire hw_write_lock_n = 1'b0;
  wire mem_blocked = (wp_q && !maddr_q[7]) || hw_write_lock_n;
  wire mem_we = rx_done && sel_q == SEL_MEM && idx_q != 8'h00 && !mem_blocked;
  wire rx_ack = !(sel_q == SEL_MEM && idx_q != 8'h00 && mem_blocked);
  wire ts_we = rx_done && sel_q == SEL_SENSOR && idx_q == 8'h02;
  wire ptr_we = rx_done && sel_q == SEL_SENSOR && idx_q == 8'h00;
  wire clr_int = ts_we && ptr_q == PTR_CFG && shift_q[CFG_CLR_BIT];

  // Temperature word and trip comparisons in quarter degrees
  wire signed [10:0] t_now = $signed({temp_q[9], temp_q});
  wire above_crit = t_now > $signed(crit_q[12:2]);
  wire above_up = t_now > $signed(upper_q[12:2]);
  wire below_low = t_now < $signed(lower_q[12:2]);
  wire [15:0] temp_word = {above_crit, above_up, below_low, temp_q[9], temp_q, 2'b00};
  // Register read selection
  wire [15:0] reg_word = (ptr_q == PTR_CAPS) ? CAPS_VAL :
                         (ptr_q == PTR_CFG) ? cfg_q :
                         (ptr_q == PTR_UPPER) ? upper_q :
                         (ptr_q == PTR_LOWER) ? lower_q :
                         (ptr_q == PTR_CRIT) ? crit_q :
                         (ptr_q == PTR_TEMP) ? temp_word :
                         (ptr_q == PTR_MAKER) ? MAKER_ID : DEVICE_ID;
  wire [7:0] tx_byte = (sel_q == SEL_SENSOR) ? (idx_q[0] ? reg_word[7:0] : reg_word[15:8]) :
                       (sel_q == SEL_MEM) ? mem_q[maddr_q] : PROT_READ_VAL;

  // Link state machine
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= D_IDLE;
      sel_q <= SEL_SENSOR;
      read_q <= 1'b0;
      bit_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      idx_q <= 8'h00;
      sda_oe_q <= 1'b0;
      maddr_q <= 8'h00;
    end else if (start_det) begin
      // Start or repeated start
      state_q <= D_ADDR;
      bit_q <= 4'h0;
      idx_q <= 8'h00;
      sda_oe_q <= 1'b0;
    end else if (stop_det) begin
      // Stop frees the bus
      state_q <= D_IDLE;
      sda_oe_q <= 1'b0;
    end else begin
      if (scl_rise && (state_q == D_ADDR || state_q == D_RX)) begin
        // Sample data, MSB first
        shift_q <= {shift_q[6:0], sda_s};
        bit_q <= bit_q + 4'd1;
      end
      if (scl_rise && state_q == D_TXACK && sda_s) begin
        // Master declined more data
        state_q <= D_IDLE;
      end
      if (scl_fall) begin
        case (state_q)
          D_ADDR: begin
            if (byte_end) begin
              // Acknowledge only a matching address
              state_q <= addr_hit ? D_ACK : D_IDLE;
              sda_oe_q <= addr_hit;
              read_q <= shift_q[0];
              sel_q <= hit_sensor ? SEL_SENSOR : (hit_mem ? SEL_MEM : SEL_PROT);
            end
          end
          D_RX: begin
            if (byte_end) begin
              // Data byte received
              state_q <= D_ACK;
              sda_oe_q <= rx_ack;
              idx_q <= idx_q + 8'd1;
              if (sel_q == SEL_MEM) begin
                maddr_q <= (idx_q == 8'h00) ? shift_q : maddr_q + 8'd1;
              end
            end
          end
          D_ACK: begin
            // End of acknowledge slot
            bit_q <= 4'h0;
            if (read_q) begin
              state_q <= D_TX;
              tx_q <= tx_byte;
              sda_oe_q <= ~tx_byte[7];
              idx_q <= idx_q + 8'd1;
              if (sel_q == SEL_MEM) begin
                maddr_q <= maddr_q + 8'd1;
              end
            end else begin
              state_q <= D_RX;
              sda_oe_q <= 1'b0;
            end
          end
          D_TX: begin
            if (bit_q == 4'd7) begin
              // Release for the master's acknowledge
              state_q <= D_TXACK;
              sda_oe_q <= 1'b0;
            end else begin
              bit_q <= bit_q + 4'd1;
              tx_q <= {tx_q[6:0], 1'b0};
              sda_oe_q <= ~tx_q[6];
            end
          end
          D_TXACK: begin
            // Acknowledged, send the next byte
            state_q <= D_TX;
            bit_q <= 4'h0;
            tx_q <= tx_byte;
            sda_oe_q <= ~tx_byte[7];
            idx_q <= idx_q + 8'd1;
            if (sel_q == SEL_MEM) begin
              maddr_q <= maddr_q + 8'd1;
            end
          end
          default: begin
            state_q <= state_q;
          end
        endcase
      end
    end
  end

  // Memory array writes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 256; i++) begin
        mem_q[i] <= MEM_RST;
      end
    end else if (mem_we) begin
      mem_q[maddr_q] <= shift_q;
    end
  end

  // Protection flag, set by a data byte to the protection address
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wp_q <= 1'b0;
    end else if (rx_done && sel_q == SEL_PROT) begin
      wp_q <= 1'b1;
    end
  end

  // Pointer and register word assembly
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ptr_q <= PTR_RST;
      msb_q <= 8'h00;
    end else if (ptr_we) begin
      ptr_q <= shift_q[2:0]; // Held for later reads
    end else if (rx_done && sel_q == SEL_SENSOR && idx_q == 8'h01) begin
      msb_q <= shift_q;
    end
  end

  // Writable sensor registers, clear bit is not stored
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_q <= CFG_RST;
      upper_q <= TRIP_RST;
      lower_q <= TRIP_RST;
      crit_q <= TRIP_RST;
    end else if (ts_we) begin
      case (ptr_q)
        PTR_CFG: cfg_q <= {msb_q, shift_q} & ~(16'h0001 << CFG_CLR_BIT);
        PTR_UPPER: upper_q <= {msb_q, shift_q};
        PTR_LOWER: lower_q <= {msb_q, shift_q};
        PTR_CRIT: crit_q <= {msb_q, shift_q};
        default: cfg_q <= cfg_q;
      endcase
    end
  end

  // Conversion pacing and result latch
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      conv_cnt_q <= 32'h0;
      conv_start <= 1'b0;
      temp_q <= TEMP_RST;
    end else begin
      conv_start <= conv_cnt_q == 32'(CONV_PERIOD - 1);
      conv_cnt_q <= (conv_cnt_q == 32'(CONV_PERIOD - 1)) ? 32'h0 : conv_cnt_q + 32'h1;
      if (conv_done) begin
        temp_q <= conv_code;
      end
    end
  end

  // Alert condition, mode and output
  wire cond = cfg_q[CFG_CRIT_ONLY_BIT] ? above_crit : (above_crit | above_up | below_low);
  wire event_now = cfg_q[CFG_MODE_BIT] ? int_q : cond;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cond_q <= 1'b0;
      int_q <= 1'b0;
      alert_q <= 1'b0;
    end else begin
      cond_q <= cond;
      if (cond && !cond_q) begin
        int_q <= 1'b1; // New event wins over a clear
      end else if (clr_int) begin
        int_q <= 1'b0;
      end
      alert_q <= cfg_q[CFG_EN_BIT] & event_now;
    end
  end

  // Open-drain outputs
  assign bus.sda_t_o = 1'b0;
  assign bus.sda_t_oe = sda_oe_q;
  assign bus.alert_o = 1'b0;
  assign bus.alert_oe = alert_q;
  assign protect_active = wp_q;
endmodule // sensor_spd_target

// File: hw/two_wire_if.sv
// Open-drain two-wire link joining the master end and the target end
`timescale 1ns/100ps
interface two_wire_if;
  logic scl_m_o; // Master clock drive value
  logic scl_m_oe; // Master pulls clock low
  logic sda_m_o; // Master data drive value
  logic sda_m_oe; // Master pulls data low
  logic sda_t_o; // Target data drive value
  logic sda_t_oe; // Target pulls data low
  logic alert_o; // Alert drive value
  logic alert_oe; // Target pulls alert low
  logic scl; // Resolved clock wire
  logic sda; // Resolved data wire
  logic alert_n; // Resolved alert wire, low when active
  // Wired-AND with pull-ups
  assign scl = !(scl_m_oe && !scl_m_o);
  assign sda = !(sda_m_oe && !sda_m_o) && !(sda_t_oe && !sda_t_o);
  assign alert_n = !(alert_oe && !alert_o);
  modport master (output scl_m_o, scl_m_oe, sda_m_o, sda_m_oe, input scl, sda, alert_n);
  modport target (output sda_t_o, sda_t_oe, alert_o, alert_oe, input scl, sda);
endinterface // two_wire_if

// File: hw/two_wire_master.sv
// Master end: issues one addressed transfer per command
`timescale 1ns/100ps
module two_wire_master
  import sensor_spd_pkg::*;
#(
  parameter int QUARTER = SCL_QUARTER_CYCLES // Cycles per quarter clock period
) (
  input wire logic clk,
  input wire logic reset_n,
  two_wire_if.master bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [6:0] cmd_addr,
  input wire logic cmd_read,
  input wire logic [1:0] cmd_len,
  input wire logic [23:0] cmd_wdata,
  output logic rsp_valid,
  output logic rsp_nack,
  output logic [15:0] rsp_data,
  output logic alert_active
);
  logic sda_s; // Synchronised data line
  logic alert_s; // Synchronised alert line
  host_state_t state_q; // Sequencer state
  logic [15:0] tick_cnt_q; // Quarter divider
  logic [1:0] ph_q; // Quarter within a bit
  logic [3:0] bit_q; // Bit in byte, 8 is acknowledge
  logic [1:0] byte_q; // Byte in transfer
  logic scl_oe_q, sda_oe_q; // Line pull-downs
  logic [7:0] addr_byte_q; // Address and read flag
  logic read_q; // Transfer reads
  logic [1:0] len_q; // Data byte count
  logic [23:0] wdata_q; // Write bytes, first in top
  logic nack_q; // Target refused

  pin_sync u_sda (.clk(clk), .reset_n(reset_n), .pin(bus.sda), .level(sda_s),
                  .rise(), .fall());
  pin_sync u_alert (.clk(clk), .reset_n(reset_n), .pin(bus.alert_n), .level(alert_s),
                    .rise(), .fall());

  // Divider tick and bit sources
  wire tick = tick_cnt_q == 16'(QUARTER - 1);
  wire last_byte = byte_q == len_q;
  wire wr_byte = byte_q == 2'd0 || !read_q;
  wire [7:0] tx_byte = (byte_q == 2'd0) ? addr_byte_q :
                       (byte_q == 2'd1) ? wdata_q[23:16] :
                       (byte_q == 2'd2) ? wdata_q[15:8] : wdata_q[7:0];
  wire tx_bit = tx_byte[3'(4'd7 - bit_q)];

  // Quarter-period divider
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_q <= 16'h0;
    end else begin
      tick_cnt_q <= tick ? 16'h0 : tick_cnt_q + 16'h1;
    end
  end

  // Bit sequencer, clock low in quarters 0 and 1
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= H_IDLE;
      ph_q <= 2'd0;
      bit_q <= 4'h0;
      byte_q <= 2'd0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      addr_byte_q <= 8'h00;
      read_q <= 1'b0;
      len_q <= 2'd0;
      wdata_q <= 24'h0;
      nack_q <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_nack <= 1'b0;
      rsp_data <= 16'h0;
    end else begin
      rsp_valid <= 1'b0;
      if (state_q == H_IDLE && cmd_valid) begin
        // Accept a command
        state_q <= H_START;
        ph_q <= 2'd0;
        addr_byte_q <= {cmd_addr, cmd_read};
        read_q <= cmd_read;
        len_q <= cmd_len;
        wdata_q <= cmd_wdata;
        nack_q <= 1'b0;
      end else if (tick && state_q != H_IDLE) begin
        ph_q <= ph_q + 2'd1;
        case (state_q)
          H_START: begin
            // Data falls while clock is high
            scl_oe_q <= ph_q == 2'd3;
            sda_oe_q <= ph_q >= 2'd1;
            if (ph_q == 2'd3) begin
              state_q <= H_BIT;
              bit_q <= 4'h0;
              byte_q <= 2'd0;
            end
          end
          H_BIT: begin
            if (ph_q == 2'd0) begin
              // Set data while clock is low
              if (bit_q == 4'd8) begin
                sda_oe_q <= !wr_byte && !last_byte;
              end else begin
                sda_oe_q <= wr_byte && !tx_bit;
              end
            end else if (ph_q == 2'd1) begin
              scl_oe_q <= 1'b0;
            end else if (ph_q == 2'd2) begin
              // Sample in the middle of the high phase
              if (bit_q == 4'd8 && wr_byte) begin
                nack_q <= sda_s;
              end else if (bit_q != 4'd8 && !wr_byte) begin
                rsp_data <= {rsp_data[14:0], sda_s};
              end
            end else begin
              scl_oe_q <= 1'b1;
              if (bit_q == 4'd8) begin
                bit_q <= 4'h0;
                byte_q <= byte_q + 2'd1;
                if (last_byte || (wr_byte && nack_q)) begin
                  state_q <= H_STOP;
                end
              end else begin
                bit_q <= bit_q + 4'd1;
              end
            end
          end
          H_STOP: begin
            // Data rises while clock is high
            scl_oe_q <= ph_q == 2'd0;
            sda_oe_q <= ph_q <= 2'd1;
            if (ph_q == 2'd3) begin
              state_q <= H_IDLE;
              rsp_valid <= 1'b1;
              rsp_nack <= nack_q;
            end
          end
          default: begin
            state_q <= H_IDLE;
          end
        endcase
      end
    end
  end

  assign cmd_ready = state_q == H_IDLE;
  assign bus.scl_m_o = 1'b0;
  assign bus.scl_m_oe = scl_oe_q;
  assign bus.sda_m_o = 1'b0;
  assign bus.sda_m_oe = sda_oe_q;
  assign alert_active = ~alert_s;
endmodule // two_wire_master

// File: test/sensor_spd_assertions.sv
// Link checks between the master end and the target end
`timescale 1ns/100ps
module sensor_spd_assertions #(
  parameter int QUARTER = 4 // Cycles per quarter link clock
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic alert_n,
  input wire logic sda_t_o,
  input wire logic sda_t_oe,
  input wire logic alert_o,
  input wire logic alert_oe
);
  logic [15:0] run_q; // Cycles of unbroken target drive
  // Counts the current target drive
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      run_q <= 16'h0000;
    end else begin
      run_q <= sda_t_oe ? run_q + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  a_alert_pull_low: assert property (alert_n == !alert_oe)
    else $error("alert wire not following its pull-down");
  a_alert_never_high: assert property (alert_o == 1'b0)
    else $error("alert driven high");
  a_data_pull_low: assert property (sda_t_oe |-> !sda)
    else $error("data wire high while target pulls it");
  a_data_never_high: assert property (sda_t_o == 1'b0)
    else $error("target drives data high");
  a_quiet_after_reset: assert property ($rose(reset_n) |-> !sda_t_oe && !alert_oe)
    else $error("target drives right after reset");
  a_change_clock_low: assert property ($changed(sda_t_oe) |->
    !scl && !$past(scl) && !$past(scl, 2))
    else $error("target data changed near a high clock");
  a_drive_steady: assert property ($changed(sda_t_oe) |=> $stable(sda_t_oe) [*3])
    else $error("target data drive glitched");
  a_drive_bounded: assert property (run_q <= 16'(36 * QUARTER + 4))
    else $error("target held data longer than nine bits");
endmodule // sensor_spd_assertions

// File: test/tb.sv
// Bench joining master and target ends over the two-wire link
`timescale 1ns/100ps
module tb;
  import sensor_spd_pkg::*;
  localparam int QTR = 4; // Quarter link clock, in cycles
  localparam int CONV = 200; // Shortened conversion period
  localparam logic [2:0] STRAP = 3'h5; // Strap setting
  localparam logic [6:0] SENS = {TYPE_SENSOR, STRAP}; // Sensor address
  localparam logic [6:0] MEM = {TYPE_MEM, STRAP}; // Memory address
  localparam logic [6:0] PROT = {TYPE_PROT, STRAP}; // Protection address
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic [6:0] cmd_addr = 7'h00;
  logic [1:0] cmd_len = 2'h0;
  logic [23:0] cmd_wdata = 24'h000000;
  logic conv_done = 1'b0; // Converter result strobe
  logic [9:0] conv_code = 10'h064; // Converter result
  logic cmd_ready, rsp_valid, rsp_nack, alert_active, conv_start, protect_active;
  logic [15:0] rsp_data;
  int fail_count = 0;
  int compares = 0;
  two_wire_if bus ();
  two_wire_master #(.QUARTER(QTR)) u_two_wire_master (.clk, .reset_n, .bus, .cmd_valid,
    .cmd_ready, .cmd_addr, .cmd_read, .cmd_len, .cmd_wdata, .rsp_valid, .rsp_nack,
    .rsp_data, .alert_active);
  sensor_spd_target #(.CONV_PERIOD(CONV)) u_sensor_spd_target (.clk, .reset_n, .bus,
    .addr_strap_bit0(STRAP[0]), .addr_strap_bit1(STRAP[1]), .addr_strap_bit2(STRAP[2]),
    .conv_start, .conv_done, .conv_code, .protect_active);
  sensor_spd_assertions #(.QUARTER(QTR)) u_sensor_spd_assertions (.clk, .reset_n,
    .scl(bus.scl), .sda(bus.sda), .alert_n(bus.alert_n), .sda_t_o(bus.sda_t_o),
    .sda_t_oe(bus.sda_t_oe), .alert_o(bus.alert_o), .alert_oe(bus.alert_oe));
  // System clock
  initial begin
    forever #12.5 clk = ~clk;
  end
  // Converter answers each request one cycle later
  always @(posedge clk) begin
    conv_done <= conv_start;
  end
  // Compare and count
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One command to the master, then wait for its response
  task automatic xfer(input logic [6:0] a, input logic rd, input logic [1:0] n,
    input logic [23:0] w);
    int k;
    @(posedge clk);
    {cmd_addr, cmd_read, cmd_len, cmd_wdata, cmd_valid} <= {a, rd, n, w, 1'b1};
    @(posedge clk);
    cmd_valid <= 1'b0;
    @(negedge clk);
    check("cmd_ready busy", 16'h0000, 16'(cmd_ready));
    for (k = 0; k < 3000 && rsp_valid !== 1'b1; k++) @(negedge clk);
    if (k == 3000) check("rsp_valid", 16'h0001, 16'h0000);
    check("cmd_ready idle", 16'h0001, 16'(cmd_ready));
  endtask
  // Sensor word write, pointer first
  task automatic sw(input logic [2:0] p, input logic [15:0] v);
    xfer(SENS, 1'b0, 2'h3, {5'h00, p, v});
  endtask
  // Sensor word read after a pointer write
  task automatic sr(input string what, input logic [2:0] p, input logic [15:0] exp);
    xfer(SENS, 1'b0, 2'h1, {5'h00, p, 16'h0000});
    xfer(SENS, 1'b1, 2'h2, 24'h000000);
    check(what, exp, rsp_data);
  endtask
  // Memory byte write with expected refusal
  task automatic mw(input logic [7:0] a, input logic [7:0] d, input logic nk);
    xfer(MEM, 1'b0, 2'h2, {a, d, 8'h00});
    check("mem write nack", 16'(nk), 16'(rsp_nack));
  endtask
  // Memory byte read at an address
  task automatic mr(input logic [7:0] a, input logic [7:0] exp);
    xfer(MEM, 1'b0, 2'h1, {a, 16'h0000});
    xfer(MEM, 1'b1, 2'h1, 24'h000000);
    check("mem read", {8'h00, exp}, {8'h00, rsp_data[7:0]});
  endtask
  // Alert level after synchronisation
  task automatic ac(input logic exp);
    repeat (8) @(negedge clk);
    check("alert_active", 16'(exp), 16'(alert_active));
  endtask
  // New temperature, then wait past one conversion
  task automatic tc(input logic [9:0] code);
    @(posedge clk);
    conv_code <= code;
    repeat (CONV + 20) @(posedge clk);
  endtask
  // Verdict and end of run
  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    logic nk;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (10) @(posedge clk);
    xfer(SENS, 1'b1, 2'h2, 24'h000000);
    check("caps", CAPS_VAL, rsp_data);
    mr(8'h00, MEM_RST);
    $display("test reset done");
    // Every type code, with good and single-bit wrong straps
    for (int i = 0; i < 32; i++) begin
      xfer({i[3:0], STRAP ^ (i[4] ? 3'(1 << (i % 3)) : 3'h0)}, 1'b0, 2'h0, 24'h000000);
      nk = i[4] || !(i[3:0] inside {TYPE_SENSOR, TYPE_MEM, TYPE_PROT});
      check("addr nack", 16'(nk), 16'(rsp_nack));
    end
    $display("test address done");
    sr("temp", PTR_TEMP, 16'hC190);
    xfer(SENS, 1'b1, 2'h2, 24'h000000);
    check("temp again", 16'hC190, rsp_data);
    sw(PTR_UPPER, 16'h0640);
    sr("upper", PTR_UPPER, 16'h0640);
    sr("temp window", PTR_TEMP, 16'h8190);
    $display("test temperature done");
    sw(PTR_CFG, 16'h0008);
    ac(1'b1);
    sw(PTR_CRIT, 16'h0640);
    ac(1'b0);
    tc(10'h3FC);
    ac(1'b1);
    sr("temp low", PTR_TEMP, 16'h3FF0);
    sw(PTR_CFG, 16'h000C);
    ac(1'b0);
    tc(10'h064);
    // Interrupt mode with the earlier sticky event cleared
    sw(PTR_CFG, 16'h0029);
    ac(1'b0);
    tc(10'h3FC);
    tc(10'h064);
    ac(1'b1);
    sw(PTR_CFG, 16'h0029);
    ac(1'b0);
    $display("test alert done");
    mw(8'h7F, 8'h5A, 1'b0);
    mr(8'h7F, 8'h5A);
    xfer(PROT, 1'b0, 2'h1, 24'h000000);
    check("protect", 16'h0001, 16'(protect_active));
    mw(8'h7F, 8'hA5, 1'b1);
    mr(8'h7F, 8'h5A);
    mw(8'h80, 8'h3C, 1'b0);
    mr(8'h80, 8'h3C);
    xfer(PROT, 1'b0, 2'h0, 24'h000000);
    check("protect nack", 16'h0001, 16'(rsp_nack));
    $display("test memory done");
    complete_run();
  end
  // Cuts a hung run short
  initial begin
    #2_000_000;
    fail_count++;
    complete_run();
  end
endmodule // tb
